/* File: hdl/sacw_map.vh */
// Purpose: Register map and field positions of the converter control block.
// Assumes: Byte registers on a 32-bit classic Wishbone bus.
// Notes: Printed offsets are not word aligned, so byte address = 4 * index.
`ifndef SACW_MAP_VH
`define SACW_MAP_VH
`define SACW_IDX_SYSCON_TWO 8'ha7
`define SACW_IDX_CONTROL 8'hf1
`define SACW_IDX_CONFIG 8'hf2
`define SACW_IDX_PAD_EN 8'hf3
`define SACW_IDX_RES_LOW 8'hf4
`define SACW_IDX_RES_HIGH 8'hf5
`define SACW_IDX_WIN_LOW 8'hf6
`define SACW_IDX_WIN_HIGH 8'hf7
`define SACW_IDX_IRQ_STATUS 8'he0
`define SACW_IDX_IRQ_MASK 8'he1
`define SACW_RESET_BYTE 8'h00
`define SACW_CTL_WINDOW_DETECT_FLAG 7
`define SACW_CTL_CONVERSION_READY_FLAG 6
`define SACW_CTL_WINSEL 5
`define SACW_CTL_WINDOW_IRQ_ENABLE 4
`define SACW_CTL_READY_IRQ_ENABLE 3
`define SACW_CTL_IDLE 1
`define SACW_CTL_START 0
`define SACW_CFG_RES 7
`define SACW_SYS_CLKX2 7
`define SACW_DIV_BASE 8'd8
`endif

/* File: hdl/sacw_top.v */
// Purpose: Control logic around an eight-channel successive-approximation
// converter: clock divider, sample, bit trials, result and window check.
// Assumes: The analog core gives a comparator bit per trial each cycle.
// Notes: Registers are bytes on a 32-bit Wishbone slave, one word each.
// Functional notes
// - Resolution bit 0 gives 8-bit conversion, 1 gives 12-bit conversion.
// - Three-bit channel field routes port-0 pin n to the converter.
// - Sample length is 2, 4, 8 or 16 conversion clocks.
// - Conversion clock is oscillator divided by 8, 16, 32 or 64.
// - Clock-double bit in system control two doubles conversion clock.
// - Writing one to start begins conversion on selected channel.
// - Ready flag sets at conversion end, cleared only by writing one.
// - Ready flag with ready enable requests an interrupt.
// - Window flag sets when result meets window condition, write one clears.
// - Polarity 0 means inside bounds, 1 means outside bounds.
// - Window flag with window enable requests an interrupt.
// - Result bits 11 to 4 compare against both bound registers.
// - Low register holds bits 3:0, high register holds bits 11:4.
// - Idle bit suspends processor clock while conversion runs.
// - Pad enable bit 1 makes pin analog, 0 leaves it digital.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`include "sacw_map.vh"
module sacw_top #(
  parameter RES_BITS = 12
) (
  input wire clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq,
  output wire conv_irq,
  output wire conv_clk,
  output reg sample_hold,
  output wire [2:0] channel_select,
  output reg [11:0] dac_trial,
  input wire comp_in,
  output wire [7:0] analog_pad_enable,
  output wire cpu_clock_hold,
  output wire busy
);
  localparam S_IDLE = 3'b001;
  localparam S_SAMPLE = 3'b010;
  localparam S_CONV = 3'b100;
  reg [7:0] syscon_two_reg;
  reg [7:0] control_reg;
  reg [7:0] config_reg;
  reg [7:0] pad_en_reg;
  reg [11:0] result_reg;
  reg [7:0] win_low_reg;
  reg [7:0] win_high_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [2:0] state_reg;
  reg [6:0] div_reg;
  reg cclk_reg;
  reg [4:0] sh_cnt_reg;
  reg [3:0] bit_reg;
  reg start_req_reg;
  wire [7:0] idx = wb_adr_i[9:2];
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire [7:0] wd = wb_dat_i[7:0];
  // Divider terminal: half period of conversion clock, in system cycles.
  reg [6:0] half_div;
  always @* begin
    case (config_reg[1:0])
      2'd0: half_div = 7'd4;
      2'd1: half_div = 7'd8;
      2'd2: half_div = 7'd16;
      default: half_div = 7'd32;
    endcase
    if (syscon_two_reg[`SACW_SYS_CLKX2])
      half_div = {1'b0, half_div[6:1]};
  end
  wire cclk_tick = (div_reg == half_div - 7'd1) & cclk_reg;
  reg [4:0] sh_len;
  always @* begin
    case (config_reg[3:2])
      2'd0: sh_len = 5'd2;
      2'd1: sh_len = 5'd4;
      2'd2: sh_len = 5'd8;
      default: sh_len = 5'd16;
    endcase
  end
  wire twelve = config_reg[`SACW_CFG_RES];
  wire [3:0] last_bit = twelve ? 4'd0 : 4'd4;
  wire [11:0] trial_done = dac_trial & ~({11'h000, 1'b1} << bit_reg) |
    ({11'h000, comp_in} << bit_reg);
  wire conv_end = (state_reg == S_CONV) & cclk_tick & (bit_reg == last_bit);
  wire [7:0] res_hi = trial_done[11:4];
  wire in_win = (res_hi >= win_low_reg) & (res_hi <= win_high_reg);
  wire win_hit = control_reg[`SACW_CTL_WINSEL] ? ~in_win : in_win;
  assign conv_clk = cclk_reg;
  assign channel_select = config_reg[6:4];
  assign analog_pad_enable = pad_en_reg;
  assign busy = (state_reg != S_IDLE);
  assign cpu_clock_hold = busy & control_reg[`SACW_CTL_IDLE];
  assign conv_irq = (control_reg[`SACW_CTL_CONVERSION_READY_FLAG] &
    control_reg[`SACW_CTL_READY_IRQ_ENABLE]) |
    (control_reg[`SACW_CTL_WINDOW_DETECT_FLAG] & control_reg[`SACW_CTL_WINDOW_IRQ_ENABLE]);
  assign irq = |(status_reg & mask_reg);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 7'd0;
      cclk_reg <= 1'b0;
    end else if (div_reg >= half_div - 7'd1) begin
      div_reg <= 7'd0;
      cclk_reg <= ~cclk_reg;
    end else begin
      div_reg <= div_reg + 7'd1;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      sh_cnt_reg <= 5'd0;
      bit_reg <= 4'd0;
      dac_trial <= 12'h000;
      sample_hold <= 1'b0;
      result_reg <= 12'h000;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_req_reg) begin
            state_reg <= S_SAMPLE;
            sh_cnt_reg <= 5'd0;
            sample_hold <= 1'b1;
          end
        end
        S_SAMPLE: begin
          if (cclk_tick) begin
            if (sh_cnt_reg == sh_len - 5'd1) begin
              state_reg <= S_CONV;
              sample_hold <= 1'b0;
              bit_reg <= 4'd11;
              dac_trial <= 12'h800;
            end else begin
              sh_cnt_reg <= sh_cnt_reg + 5'd1;
            end
          end
        end
        S_CONV: begin
          if (cclk_tick) begin
            if (bit_reg == last_bit) begin
              result_reg <= trial_done;
              state_reg <= S_IDLE;
            end else begin
              dac_trial <= trial_done | ({11'h000, 1'b1} << (bit_reg - 4'd1));
              bit_reg <= bit_reg - 4'd1;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // Software writes and hardware flag sets; a set wins over a clear.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syscon_two_reg <= `SACW_RESET_BYTE;
      control_reg <= `SACW_RESET_BYTE;
      config_reg <= `SACW_RESET_BYTE;
      pad_en_reg <= `SACW_RESET_BYTE;
      win_low_reg <= `SACW_RESET_BYTE;
      win_high_reg <= `SACW_RESET_BYTE;
      mask_reg <= 2'b00;
      status_reg <= 2'b00;
      start_req_reg <= 1'b0;
    end else begin
      start_req_reg <= 1'b0;
      if (wr) begin
        case (idx)
          `SACW_IDX_SYSCON_TWO: syscon_two_reg <= wd;
          `SACW_IDX_CONFIG: config_reg <= wd;
          `SACW_IDX_PAD_EN: pad_en_reg <= wd;
          `SACW_IDX_WIN_LOW: win_low_reg <= wd;
          `SACW_IDX_WIN_HIGH: win_high_reg <= wd;
          `SACW_IDX_IRQ_MASK: mask_reg <= wd[1:0];
          `SACW_IDX_CONTROL: begin
            control_reg[5:1] <= wd[5:1];
            control_reg[`SACW_CTL_START] <= wd[`SACW_CTL_START] | busy;
            start_req_reg <= wd[`SACW_CTL_START] & ~busy;
            if (wd[`SACW_CTL_CONVERSION_READY_FLAG])
              control_reg[`SACW_CTL_CONVERSION_READY_FLAG] <= 1'b0;
            if (wd[`SACW_CTL_WINDOW_DETECT_FLAG])
              control_reg[`SACW_CTL_WINDOW_DETECT_FLAG] <= 1'b0;
          end
          default: ;
        endcase
      end
      if (rd && idx == `SACW_IDX_IRQ_STATUS)
        status_reg <= 2'b00;
      if (conv_end) begin
        control_reg[`SACW_CTL_START] <= 1'b0;
        control_reg[`SACW_CTL_CONVERSION_READY_FLAG] <= 1'b1;
        status_reg[0] <= 1'b1;
        if (win_hit) begin
          control_reg[`SACW_CTL_WINDOW_DETECT_FLAG] <= 1'b1;
          status_reg[1] <= 1'b1;
        end
      end
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        case (idx)
          `SACW_IDX_SYSCON_TWO: wb_dat_o[7:0] <= syscon_two_reg;
          `SACW_IDX_CONTROL: wb_dat_o[7:0] <= {control_reg[7:1], busy};
          `SACW_IDX_CONFIG: wb_dat_o[7:0] <= config_reg;
          `SACW_IDX_PAD_EN: wb_dat_o[7:0] <= pad_en_reg;
          `SACW_IDX_RES_LOW: wb_dat_o[7:0] <= {4'h0, result_reg[3:0]};
          `SACW_IDX_RES_HIGH: wb_dat_o[7:0] <= result_reg[11:4];
          `SACW_IDX_WIN_LOW: wb_dat_o[7:0] <= win_low_reg;
          `SACW_IDX_WIN_HIGH: wb_dat_o[7:0] <= win_high_reg;
          `SACW_IDX_IRQ_STATUS: wb_dat_o[7:0] <= {6'h00, status_reg};
          `SACW_IDX_IRQ_MASK: wb_dat_o[7:0] <= {6'h00, mask_reg};
          default: wb_dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* File: test/sacw_core_model.sv */
// Purpose: Comparator and pads beyond the converter control.
// Assumes: A trial bit stays when the trial is at or below the level.
// Notes: A pin left digital gives a level that flips every cycle.
`timescale 1ns/100ps
module sacw_core_model (
  input wire clk,
  input wire [95:0] levels,
  input wire [2:0] channel_select,
  input wire [7:0] analog_pad_enable,
  input wire [11:0] dac_trial,
  output wire comp_in
);
  reg flip = 1'b0;
  always @(posedge clk) begin
    flip <= ~flip;
  end
  assign comp_in = analog_pad_enable[channel_select] ?
    dac_trial <= levels[channel_select * 12 +: 12] : flip;
endmodule

/* File: test/sacw_props.sv */
// Purpose: Port assertions for the converter control block.
// Assumes: One clock, reset asynchronous and active low.
// Notes: Byte writes count only with sel bit 0 set.
`timescale 1ns/100ps
module sacw_props (
  input wire clk, input wire arst_n, input wire wb_cyc_i,
  input wire wb_stb_i, input wire wb_we_i, input wire [3:0] wb_sel_i,
  input wire [9:0] wb_adr_i, input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o, input wire wb_ack_o, input wire busy,
  input wire sample_hold, input wire [11:0] dac_trial,
  input wire [2:0] channel_select, input wire [7:0] analog_pad_enable,
  input wire cpu_clock_hold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_wr(idx);
    s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx);
  endsequence
  a_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad ack");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stray read data");
  a_start_busy: assert property (
    s_wr(8'hf1) ##0 (wb_dat_i[0] && !busy) |-> ##[2:3] busy)
    else $error("start lost");
  a_pad_write: assert property (s_wr(8'hf3) |=>
    analog_pad_enable == $past(wb_dat_i[7:0])) else $error("pad enable");
  a_chan_write: assert property (s_wr(8'hf2) |=>
    channel_select == $past(wb_dat_i[6:4])) else $error("channel");
  a_hold_busy: assert property (cpu_clock_hold |-> busy)
    else $error("hold while idle");
  a_sample_busy: assert property (sample_hold |-> busy)
    else $error("sample while idle");
  a_trial_first: assert property (
    $fell(sample_hold) && $past(arst_n) |-> busy && dac_trial == 12'h800)
    else $error("first trial");
endmodule
bind sacw_top sacw_props u_props (.clk, .arst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy,
  .sample_hold, .dac_trial, .channel_select, .analog_pad_enable,
  .cpu_clock_hold);

/* File: test/sacw_top_tb.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Random levels; the model predicts result, flags and timing.
// Notes: Sample span is only bounded, as ticks start off any edge.
`timescale 1ns/100ps
module sacw_top_tb;
  reg clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0, w, pc;
  reg [9:0] wb_adr_i = 10'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg [95:0] levels = 96'h0;
  reg [63:0] idx = 64'ha7f1f2f3f6f7e0e1;
  reg [7:0] q, cfg, ctl;
  reg [11:0] e;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq, conv_irq, conv_clk, sample_hold, comp_in, busy;
  wire cpu_clock_hold;
  wire [2:0] channel_select;
  wire [11:0] dac_trial;
  wire [7:0] analog_pad_enable;
  integer fail_count = 0, tests_run = 0, seed = 32'hccb86754, cyc_n = 0;
  integer k, p, per, n, shc, lr, r;
  sacw_top u_dut (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .conv_irq,
    .conv_clk, .sample_hold, .channel_select, .dac_trial, .comp_in,
    .analog_pad_enable, .cpu_clock_hold, .busy);
  sacw_core_model u_core (.clk, .levels, .channel_select,
    .analog_pad_enable, .dac_trial, .comp_in);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Ack is read before the edge's updates land, as a flop would see it.
  task bus(input wr, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {3'b11, wr, a,
        2'b00, 24'h0, d};
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      q = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i} <= 2'b00;
    end
  endtask
  task complete_run;
    begin
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 40000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (k = 0; k < 8; k = k + 1) begin
      bus(0, idx[k * 8 +: 8], 8'h00);
      chk(q, 0);
    end
    bus(1, 8'h10, 8'hff);
    bus(0, 8'h10, 8'h00);
    chk(q, 0);
    for (k = 0; k < 10; k = k + 1) begin
      r = $random(seed);
      levels = {$random(seed), $random(seed), $random(seed)};
      cfg = {k[0], r[6:0]};
      ctl = {2'b11, r[27:25], 1'b0, r[24], 1'b1};
      e = levels[cfg[6:4] * 12 +: 12] & {8'hff, {4{cfg[7]}}};
      w = (e[11:4] >= r[15:8] && e[11:4] <= r[23:16]) ^ ctl[5];
      p = (8 << cfg[1:0]) >> r[28];
      bus(1, 8'ha7, {r[28], 7'h0});
      bus(1, 8'hf3, r[31:24] | 8'h01 << cfg[6:4]);
      bus(1, 8'hf2, cfg);
      bus(1, 8'hf6, r[15:8]);
      bus(1, 8'hf7, r[23:16]);
      bus(1, 8'he1, 8'h03);
      bus(1, 8'hf1, ctl);
      {n, shc, lr, per} = 0;
      pc = conv_clk;
      while (n < 3 || busy !== 1'b0) begin
        @(posedge clk);
        n = n + 1;
        shc = shc + sample_hold;
        if (busy === 1'b1) chk(cpu_clock_hold, ctl[1]);
        if (conv_clk && !pc && lr > 0) per = n - lr;
        if (conv_clk && !pc) lr = n;
        pc = conv_clk;
      end
      chk(per, p);
      chk(shc > (2 * p << cfg[3:2]) - p && shc <= (2 * p << cfg[3:2]), 1);
      chk(irq, 1);
      chk(conv_irq, ctl[3] | ctl[4] & w);
      bus(0, 8'hf1, 8'h00);
      chk(q, {w, 1'b1, ctl[5:1], 1'b0});
      bus(0, 8'hf4, 8'h00);
      chk(q[3:0], e[3:0]);
      bus(0, 8'hf5, 8'h00);
      chk(q, e[11:4]);
      bus(0, 8'he0, 8'h00);
      chk(q, {6'h0, w, 1'b1});
      bus(1, 8'hf1, 8'hc0);
      bus(0, 8'hf1, 8'h00);
      chk({q, irq, conv_irq}, 0);
    end
    complete_run;
  end
endmodule
